// ---- logic/fpo_core.sv ----
// Protection override command sequencer with register port
`timescale 1ns/1ps
module fpo_core
  import fpo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] stored_key,
  input wire logic cmd_allowed,
  input wire logic single_fault_event,
  output logic cmd_irq,
  output logic fault_irq,
  output logic wake_req
);
  // Key, mode strap and single fault event come from other domains
  logic [15:0] key_s1_ff, key_s2_ff;
  logic allow_s1_ff, allow_s2_ff;
  logic fault_s1_ff, fault_s2_ff, fault_s3_ff;

  logic [15:0] words_ff [0:3];
  logic [15:0] nxt_words [0:3];
  logic [2:0] index_ff, nxt_index;
  logic cmd_complete_flag_ff, nxt_cmd_complete_flag;
  logic acc_ff, nxt_acc;
  logic viol_ff, nxt_viol;
  logic cmd_complete_irq_en_ff, nxt_cmd_complete_irq_en;
  logic single_fault_irq_en_ff, nxt_single_fault_irq_en;
  logic single_fault_flag_ff, nxt_single_fault_flag;
  logic [7:0] pf_prot_ff, nxt_pf_prot;
  logic [7:0] ee_prot_ff, nxt_ee_prot;
  logic [7:0] pf_save_ff, nxt_pf_save;
  logic [7:0] ee_save_ff, nxt_ee_save;
  logic ovr_ff, nxt_ovr;
  logic [15:0] rdata_ff, nxt_rdata;
  logic cmd_irq_ff, fault_irq_ff, wake_ff;
  fpo_state_e state_ff, nxt_state;

  function automatic logic is_valid_index(input logic [2:0] ix);
    is_valid_index = (ix == FPO_IX_1) || (ix == FPO_IX_2) || (ix == FPO_IX_3);
  endfunction : is_valid_index

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      key_s1_ff <= 16'hFFFF;
      key_s2_ff <= 16'hFFFF;
      allow_s1_ff <= 1'b0;
      allow_s2_ff <= 1'b0;
      fault_s1_ff <= 1'b0;
      fault_s2_ff <= 1'b0;
      fault_s3_ff <= 1'b0;
    end else if (clk_en) begin
      key_s1_ff <= stored_key;
      key_s2_ff <= key_s1_ff;
      allow_s1_ff <= cmd_allowed;
      allow_s2_ff <= allow_s1_ff;
      fault_s1_ff <= single_fault_event;
      fault_s2_ff <= fault_s1_ff;
      fault_s3_ff <= fault_s2_ff;
    end
  end

  logic wr_cmd_complete_flag_clear;
  logic [1:0] sel;
  logic key_inv, key_match, err, restore;
  logic fault_rise;

  always_comb begin
    wr_cmd_complete_flag_clear = reg_wr && (reg_addr == FPO_A_STATE) && reg_wdata[FPO_ST_CMD_COMPLETE_FLAG_BIT]
                    && cmd_complete_flag_ff; // see RULE23
    sel = words_ff[0][1:0]; // see RULE1
    key_inv = (words_ff[1] == FPO_KEY_INVALID); // see RULE5
    key_match = !key_inv && (key_s2_ff != FPO_KEY_INVALID)
                && (words_ff[1] == key_s2_ff); // see RULE2 see RULE11
    restore = !key_match; // see RULE6 see RULE10
    fault_rise = fault_s2_ff && !fault_s3_ff;
    err = 1'b0;
    if (!is_valid_index(index_ff)) err = 1'b1; // see RULE15
    if (!allow_s2_ff) err = 1'b1; // see RULE16
    if (words_ff[0][15:8] != FPO_CMD_OVERRIDE) err = 1'b1;
    if (restore && !ovr_ff) err = 1'b1; // see RULE17
    if ((sel == FPO_SEL_NONE) && (index_ff != FPO_IX_1)) err = 1'b1; // see RULE18
    if ((sel == FPO_SEL_NONE) && (index_ff == FPO_IX_1) && !key_inv) err = 1'b1; // see RULE19
  end

  always_comb begin
    for (int i = 0; i < 4; i++) nxt_words[i] = words_ff[i];
    nxt_index = index_ff;
    nxt_cmd_complete_flag = cmd_complete_flag_ff;
    nxt_acc = acc_ff;
    nxt_viol = viol_ff;
    nxt_cmd_complete_irq_en = cmd_complete_irq_en_ff;
    nxt_single_fault_irq_en = single_fault_irq_en_ff;
    nxt_single_fault_flag = single_fault_flag_ff;
    nxt_pf_prot = pf_prot_ff;
    nxt_ee_prot = ee_prot_ff;
    nxt_pf_save = pf_save_ff;
    nxt_ee_save = ee_save_ff;
    nxt_ovr = ovr_ff;
    nxt_state = state_ff;
    nxt_rdata = 16'h0000;
    if (reg_wr) begin
      case (reg_addr)
        FPO_A_CMD_WORD: if (cmd_complete_flag_ff) nxt_words[index_ff[1:0]] = reg_wdata;
        FPO_A_INDEX: nxt_index = reg_wdata[2:0];
        FPO_A_STATE: begin
          if (reg_wdata[FPO_ST_ACC_BIT]) nxt_acc = 1'b0;
          if (reg_wdata[FPO_ST_VIOL_BIT]) nxt_viol = 1'b0;
        end
        FPO_A_CONFIG: nxt_cmd_complete_irq_en = reg_wdata[FPO_CFG_CMD_COMPLETE_IRQ_EN_BIT];
        FPO_A_FAULT_CFG: nxt_single_fault_irq_en = reg_wdata[FPO_FAULT_BIT];
        FPO_A_FAULT_STATE: if (reg_wdata[FPO_FAULT_BIT]) nxt_single_fault_flag = 1'b0;
        FPO_A_PFLASH_PROT: nxt_pf_prot = reg_wdata[7:0];
        FPO_A_EEPROM_PROT: nxt_ee_prot = reg_wdata[7:0];
        default: ;
      endcase
    end
    if (fault_rise) nxt_single_fault_flag = 1'b1;
    case (state_ff)
      FPO_IDLE: begin
        if (wr_cmd_complete_flag_clear && !acc_ff && !viol_ff) begin
          nxt_cmd_complete_flag = 1'b0; // see RULE23
          nxt_state = FPO_EXEC;
        end
      end
      FPO_EXEC: begin
        if (err) begin
          nxt_acc = 1'b1; // see RULE12
        end else if (key_match) begin
          nxt_pf_save = pf_prot_ff; // see RULE7 see RULE13
          nxt_ee_save = ee_prot_ff;
          if (sel[FPO_SEL_PF_BIT]) nxt_pf_prot = words_ff[2][7:0]; // see RULE3 see RULE8
          if (sel[FPO_SEL_EE_BIT]) nxt_ee_prot = words_ff[3][7:0]; // see RULE4
          nxt_ovr = 1'b1; // see RULE9
        end else begin
          nxt_pf_prot = pf_save_ff; // see RULE10 see RULE14
          nxt_ee_prot = ee_save_ff;
          nxt_ovr = 1'b0;
        end
        nxt_state = FPO_DONE;
      end
      FPO_DONE: begin
        nxt_cmd_complete_flag = 1'b1; // see RULE23
        nxt_state = FPO_IDLE;
      end
      default: nxt_state = FPO_IDLE;
    endcase
    if (reg_rd) begin
      case (reg_addr)
        FPO_A_CMD_WORD: nxt_rdata = words_ff[index_ff[1:0]];
        FPO_A_INDEX: nxt_rdata = {13'h0000, index_ff};
        FPO_A_STATE: nxt_rdata = {8'h00, cmd_complete_flag_ff, 1'b0, acc_ff, viol_ff, 4'h0};
        FPO_A_CONFIG: nxt_rdata = {8'h00, cmd_complete_irq_en_ff, 7'h00};
        FPO_A_FAULT_CFG: nxt_rdata = {15'h0000, single_fault_irq_en_ff};
        FPO_A_FAULT_STATE: nxt_rdata = {15'h0000, single_fault_flag_ff};
        FPO_A_PFLASH_PROT: nxt_rdata = {8'h00, pf_prot_ff};
        FPO_A_EEPROM_PROT: nxt_rdata = {8'h00, ee_prot_ff};
        FPO_A_PROT_STATUS: nxt_rdata = {15'h0000, ovr_ff};
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) words_ff[i] <= 16'h0000;
      index_ff <= 3'h0;
      cmd_complete_flag_ff <= 1'b1;
      acc_ff <= 1'b0;
      viol_ff <= 1'b0;
      cmd_complete_irq_en_ff <= 1'b0;
      single_fault_irq_en_ff <= 1'b0;
      single_fault_flag_ff <= 1'b0;
      pf_prot_ff <= FPO_PROT_RESET;
      ee_prot_ff <= FPO_PROT_RESET;
      pf_save_ff <= FPO_PROT_RESET;
      ee_save_ff <= FPO_PROT_RESET;
      ovr_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      state_ff <= FPO_IDLE;
    end else if (clk_en) begin
      for (int i = 0; i < 4; i++) words_ff[i] <= nxt_words[i];
      index_ff <= nxt_index;
      cmd_complete_flag_ff <= nxt_cmd_complete_flag;
      acc_ff <= nxt_acc;
      viol_ff <= nxt_viol;
      cmd_complete_irq_en_ff <= nxt_cmd_complete_irq_en;
      single_fault_irq_en_ff <= nxt_single_fault_irq_en;
      single_fault_flag_ff <= nxt_single_fault_flag;
      pf_prot_ff <= nxt_pf_prot;
      ee_prot_ff <= nxt_ee_prot;
      pf_save_ff <= nxt_pf_save;
      ee_save_ff <= nxt_ee_save;
      ovr_ff <= nxt_ovr;
      rdata_ff <= nxt_rdata;
      state_ff <= nxt_state;
    end
  end

  // Interrupt levels registered from next flag values, so no lag vs flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_irq_ff <= 1'b0;
      fault_irq_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else if (clk_en) begin
      cmd_irq_ff <= nxt_cmd_complete_flag && nxt_cmd_complete_irq_en; // see RULE20 see RULE24
      fault_irq_ff <= nxt_single_fault_flag && nxt_single_fault_irq_en; // see RULE21 see RULE24
      wake_ff <= nxt_cmd_complete_flag && nxt_cmd_complete_irq_en; // see RULE22
    end
  end

  assign reg_rdata = rdata_ff;
  assign cmd_irq = cmd_irq_ff;
  assign fault_irq = fault_irq_ff;
  assign wake_req = wake_ff;
endmodule : fpo_core

// ---- logic/fpo_pkg.sv ----
// Constants and types for the flash protection override sequencer
// Notes on behaviour
// RULE1: Override command is code 13h in word 0 upper byte, selection in low bits.
// RULE2: Compare key from word 1 against stored configuration key.
// RULE3: Selection bit 0 with match loads pflash protection from word 2 low byte.
// RULE4: Selection bit 1 with match loads eeprom protection from word 3 low byte.
// RULE5: Supplied key FFFFh is invalid and disables the override.
// RULE6: Valid key differing from stored key disables the override.
// RULE7: On match save both protection values before overwriting.
// RULE8: New protection values are taken without restriction.
// RULE9: Successful override sets override active.
// RULE10: Mismatch or invalid key restores both and clears override active.
// RULE11: Erased stored key FFFFh never lets an override succeed.
// RULE12: Access error leaves both protection registers unchanged.
// RULE13: Single-entry save area, overwritten each launch, restored on demand; code overwrites it only on a successful override.
// RULE14: Restore overrides direct writes and loads saved, not reset, values.
// RULE15: Access error unless index at launch is 001, 010 or 011.
// RULE16: Access error when command not allowed in current mode.
// RULE17: Access error when restore needed but override active is zero.
// RULE18: Access error for selection 00 with index 010 or 011.
// RULE19: Access error for selection 00, index 001 and a valid key.
// RULE20: Command interrupt when complete flag and its enable are set.
// RULE21: Error interrupt when single fault flag and its enable are set.
// RULE22: Works in wait mode; complete interrupt wakes processor.
// RULE23: Software launches by clearing complete flag; device sets it at finish.
// RULE24: Interrupt requests are levels following flag and enable.
package fpo_pkg;
  localparam logic [3:0] FPO_A_CMD_WORD = 4'h0;
  localparam logic [3:0] FPO_A_INDEX = 4'h1;
  localparam logic [3:0] FPO_A_STATE = 4'h2;
  localparam logic [3:0] FPO_A_CONFIG = 4'h3;
  localparam logic [3:0] FPO_A_FAULT_CFG = 4'h4;
  localparam logic [3:0] FPO_A_FAULT_STATE = 4'h5;
  localparam logic [3:0] FPO_A_PFLASH_PROT = 4'h6;
  localparam logic [3:0] FPO_A_EEPROM_PROT = 4'h7;
  localparam logic [3:0] FPO_A_PROT_STATUS = 4'h8;
  localparam logic [7:0] FPO_CMD_OVERRIDE = 8'h13;
  localparam logic [15:0] FPO_KEY_INVALID = 16'hFFFF;
  localparam logic [2:0] FPO_IX_1 = 3'h1;
  localparam logic [2:0] FPO_IX_2 = 3'h2;
  localparam logic [2:0] FPO_IX_3 = 3'h3;
  localparam logic [1:0] FPO_SEL_NONE = 2'h0;
  localparam int FPO_SEL_PF_BIT = 0;
  localparam int FPO_SEL_EE_BIT = 1;
  // State register bits
  localparam int FPO_ST_CMD_COMPLETE_FLAG_BIT = 7;
  localparam int FPO_ST_ACC_BIT = 5;
  localparam int FPO_ST_VIOL_BIT = 4;
  // Config / fault / status bits
  localparam int FPO_CFG_CMD_COMPLETE_IRQ_EN_BIT = 7;
  localparam int FPO_FAULT_BIT = 0;
  localparam int FPO_STAT_OVR_BIT = 0;
  localparam logic [7:0] FPO_PROT_RESET = 8'hFF;
  typedef enum logic [2:0] {
    FPO_IDLE = 3'b001,
    FPO_EXEC = 3'b010,
    FPO_DONE = 3'b100
  } fpo_state_e;
endpackage : fpo_pkg

// ---- sim/flash_protection_override_irq_tb_top.sv ----
// Register-level bench for the protection override sequencer
`timescale 1ns/1ps
module flash_protection_override_irq_tb_top import fpo_pkg::*;;
  logic clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic cmd_allowed = 1'b1, single_fault_event = 1'b0, cmd_irq, fault_irq, wake_req;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, stored_key = 16'h5A3C, reg_rdata, v;
  logic [7:0] pf_m = 8'hFF, ee_m = 8'hFF, sv_pf = 8'hFF, sv_ee = 8'hFF;
  logic ovr_m = 1'b0;
  int num_errors = 0, total_checks = 0, cyc = 0;
  always #20 clk_sys = ~clk_sys;
  fpo_core uut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stored_key(stored_key), .cmd_allowed(cmd_allowed),
    .single_fault_event(single_fault_event), .cmd_irq(cmd_irq), .fault_irq(fault_irq),
    .wake_req(wake_req));
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask : rd
  task automatic launch(input logic [1:0] sel, input logic [15:0] key, input logic [7:0] pf,
    input logic [7:0] ee, input logic [2:0] ix);
    logic hit, err;
    wr(4'h1, 16'h0000); wr(4'h0, {FPO_CMD_OVERRIDE, 6'h00, sel});
    wr(4'h1, 16'h0001); wr(4'h0, key);
    wr(4'h1, 16'h0002); wr(4'h0, {8'h00, pf});
    wr(4'h1, 16'h0003); wr(4'h0, {8'h00, ee});
    wr(4'h1, {13'h0000, ix}); wr(4'h2, 16'h0080);
    repeat (4) @(posedge clk_sys);
    hit = key != FPO_KEY_INVALID && key == stored_key && stored_key != FPO_KEY_INVALID;
    err = ix == 3'h0 || ix > FPO_IX_3 || !cmd_allowed || (!hit && !ovr_m) ||
      (sel == FPO_SEL_NONE && (ix != FPO_IX_1 || key != FPO_KEY_INVALID));
    if (!err && hit) begin
      sv_pf = pf_m; sv_ee = ee_m; ovr_m = 1'b1;
      if (sel[0]) pf_m = pf;
      if (sel[1]) ee_m = ee;
    end else if (!err) begin
      pf_m = sv_pf; ee_m = sv_ee; ovr_m = 1'b0;
    end
    rd(4'h2, v); chk(v & 16'h00B0, {8'h00, 2'b10, err, 5'h00});
    wr(4'h2, 16'h0030);
    rd(4'h6, v); chk(v, {8'h00, pf_m});
    rd(4'h7, v); chk(v, {8'h00, ee_m});
    rd(4'h8, v); chk(v, {15'h0000, ovr_m});
    chk({14'h0000, wake_req, cmd_irq}, 16'h0003);
    $display("test sel=%0d ix=%0d end", sel, ix);
  endtask : launch
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(4'h6, v); chk(v, 16'h00FF);
    rd(4'hF, v); chk(v, 16'h0000);
    wr(4'h3, 16'h0000); wr(4'h3, 16'h0080);
    launch(2'h1, 16'h1111, 8'h00, 8'h00, 3'h3);
    launch(2'h1, 16'h5A3C, 8'h00, 8'h11, 3'h3);
    wr(4'h6, 16'h0042); pf_m = 8'h42;
    launch(2'h2, 16'h5A3C, 8'h00, 8'h20, 3'h3);
    wr(4'h7, 16'h0077); ee_m = 8'h77;
    launch(2'h0, 16'hFFFF, 8'h00, 8'h00, 3'h1);
    launch(2'h3, 16'h5A3C, 8'h01, 8'h02, 3'h0);
    launch(2'h3, 16'h5A3C, 8'h01, 8'h02, 3'h4);
    launch(2'h0, 16'h5A3C, 8'h01, 8'h02, 3'h2);
    launch(2'h0, 16'h5A3C, 8'h01, 8'h02, 3'h1);
    cmd_allowed <= 1'b0;
    launch(2'h3, 16'h5A3C, 8'h03, 8'h04, 3'h3);
    cmd_allowed <= 1'b1;
    launch(2'h3, 16'h5A3C, 8'h05, 8'h06, 3'h3);
    launch(2'h1, 16'h2222, 8'h00, 8'h00, 3'h3);
    launch(2'h3, 16'h5A3C, 8'h07, 8'h08, 3'h3);
    wr(4'h1, 16'h0000); wr(4'h0, 16'h1203);
    wr(4'h1, 16'h0003); wr(4'h2, 16'h0080);
    repeat (4) @(posedge clk_sys);
    rd(4'h2, v); chk(v & 16'h00B0, 16'h00A0);
    wr(4'h2, 16'h0030);
    rd(4'h6, v); chk(v, {8'h00, pf_m});
    rd(4'h7, v); chk(v, {8'h00, ee_m});
    $display("test opcode end");
    stored_key <= 16'hFFFF;
    launch(2'h3, 16'hFFFF, 8'h09, 8'h0A, 3'h3);
    launch(2'h3, 16'h1234, 8'h09, 8'h0A, 3'h3);
    rd(4'h8, v); #1 chk(reg_rdata, 16'h0000);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(4'h6, 16'h0055);
    clk_en <= 1'b1;
    rd(4'h6, v); chk(v, {8'h00, pf_m});
    $display("test freeze end");
    wr(4'h4, 16'h0001);
    single_fault_event <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk({15'h0000, fault_irq}, 16'h0001);
    single_fault_event <= 1'b0;
    wr(4'h5, 16'h0001); chk({15'h0000, fault_irq}, 16'h0000);
    wr(4'h4, 16'h0000);
    wr(4'h3, 16'h0000); chk({15'h0000, cmd_irq}, 16'h0000);
    $display("test irq end");
    give_verdict();
  end
endmodule : flash_protection_override_irq_tb_top
bind fpo_core fpo_core_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .stored_key(stored_key), .cmd_allowed(cmd_allowed),
  .single_fault_event(single_fault_event), .cmd_irq(cmd_irq), .fault_irq(fault_irq),
  .wake_req(wake_req));

// ---- sim/fpo_core_asserts.sv ----
// Port-level checks for the protection override sequencer
`timescale 1ns/1ps
module fpo_core_asserts
  import fpo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] stored_key,
  input wire logic cmd_allowed,
  input wire logic single_fault_event,
  input wire logic cmd_irq,
  input wire logic fault_irq,
  input wire logic wake_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_WAKE: assert property (wake_req == cmd_irq)
    else $error("wake differs from command irq");
  AST_CMD_COMPLETE_IRQ_EN_OFF: assert property (reg_wr && reg_addr == FPO_A_CONFIG &&
    !reg_wdata[FPO_CFG_CMD_COMPLETE_IRQ_EN_BIT] |=> !cmd_irq) else $error("cmd irq not masked");
  AST_SINGLE_FAULT_IRQ_EN_OFF: assert property (reg_wr && reg_addr == FPO_A_FAULT_CFG &&
    !reg_wdata[FPO_FAULT_BIT] |=> !fault_irq) else $error("fault irq not masked");
  AST_SINGLE_FAULT_FLAG_CLR: assert property (reg_wr && reg_addr == FPO_A_FAULT_STATE &&
    reg_wdata[FPO_FAULT_BIT] |=> !fault_irq) else $error("fault irq not cleared");
  AST_LAUNCH: assert property ($fell(cmd_irq) && $past(reg_addr) == FPO_A_STATE |->
    ##1 !cmd_irq ##1 cmd_irq) else $error("completion not three cycles after launch");
  AST_CMD_COMPLETE_FLAG_RD: assert property (reg_rd && reg_addr == FPO_A_STATE && cmd_irq |=>
    reg_rdata[FPO_ST_CMD_COMPLETE_FLAG_BIT]) else $error("complete flag reads low");
  AST_OVR_RD: assert property (reg_rd && reg_addr == FPO_A_PROT_STATUS |=>
    reg_rdata[15:1] == 15'h0000) else $error("status upper bits set");
  AST_IRQ_HOLD: assert property ($fell(cmd_irq) || $fell(fault_irq) |->
    $past(reg_wr)) else $error("irq dropped without a write");
  cover property ($fell(cmd_irq));
  cover property ($rose(fault_irq));
  cover property (reg_rd && reg_addr == FPO_A_PROT_STATUS);
endmodule : fpo_core_asserts
